// File: rtl/acc_adc_ctrl.sv
// converter control: start, timing, result, flags and pseudo idle
// Operation
// R1 - one of eight inputs routed to converter
// R2 - standard eight-bit and precision ten-bit modes
// R3 - each conversion yields ten-bit result
// R4 - software sets pseudo idle then starts
// R5 - precision conversion halts cpu, peripherals run
// R6 - only end interrupt wakes cpu
// R7 - other interrupts held until conversion ends
// R8 - config bit picks analog or port pin
// R9 - unconfigured pins stay general purpose
// R10 - start on unconfigured channel does nothing
// R11 - conversion lasts eleven adc clock periods
// R12 - software waits setup after enable
// R13 - completion shown by flag and interrupt
// R14 - start bit begins, hardware clears it
// R15 - hardware sets end flag, software clears
// R16 - three-bit field selects input binary
// R17 - enable clear gives standby, no conversions
// R18 - start during conversion is ignored
module acc_adc_ctrl (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    // software control
    input  wire acc_pkg::acc_ctrl_s         ctrl,
    input  wire logic [acc_pkg::PRS_W-1:0]  prescale,
    input  wire logic [acc_pkg::NUM_CH-1:0] channel_config_reg,
    input  wire logic                       eoc_interrupt_enable,
    // analog front end
    input  wire logic [acc_pkg::RES_W-1:0]  ch_code [acc_pkg::NUM_CH],
    // other interrupt sources of the chip
    input  wire logic                       other_irq_in,
    // status
    output acc_pkg::acc_stat_s              status,
    output logic                            eoc_irq,
    output logic                            other_irq_out,
    output logic                            cpu_halt,
    output logic                            sample_hold,
    output logic [acc_pkg::NUM_CH-1:0]      pin_is_analog
);
    acc_pkg::acc_state_e             state_r;
    acc_pkg::acc_state_e             state_nxt;
    logic [acc_pkg::CNT_W-1:0]       cnt_r;
    logic [acc_pkg::CNT_W-1:0]       cnt_nxt;
    logic                            busy_r;
    logic                            eoc_r;
    logic                            prec_r;
    logic [acc_pkg::RES_W-1:0]       sample_r;
    logic [acc_pkg::RES_W-1:0]       result_r;
    logic [acc_pkg::NUM_CH-1:0]      pin_r;
    logic                            irq_r;
    logic                            oirq_r;
    logic                            halt_r;
    logic                            sh_r;
    logic                            adc_tick;
    logic [acc_pkg::RES_W-1:0]       sel_code;
    logic                            ch_ok;
    logic [acc_pkg::NUM_CH-1:0]      pin_w;

    // channel multiplexer
    acc_chan_mux u_mux (
        .channel_select_field (ctrl.channel_select_field),
        .channel_config_reg   (channel_config_reg),
        .ch_code              (ch_code),
        .selected_analog_input(sel_code),
        .channel_allowed      (ch_ok),
        .pin_is_analog        (pin_w)
    );

    // adc clock, stopped in standby
    acc_prescaler u_prs (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .run     (ctrl.converter_enable), // see R17
        .prs     (prescale),
        .adc_tick(adc_tick)
    );

    // start accepted only when enabled, idle and channel configured
    wire start_ok  = ctrl.start_write && ctrl.converter_enable && !busy_r && ch_ok; // see R10 see R18 see R17
    wire in_sample = (state_r == acc_pkg::ACC_SAMPLE);
    wire in_conv   = (state_r == acc_pkg::ACC_CONVERT);
    wire last_bit  = in_conv && adc_tick && (cnt_r == acc_pkg::BIT_PERIODS - 4'h1);
    wire done      = last_bit;
    // standard mode keeps eight useful bits, precision keeps ten
    wire [acc_pkg::RES_W-1:0] std_mask = {{acc_pkg::STD_BITS{1'b1}}, {(acc_pkg::RES_W-acc_pkg::STD_BITS){1'b0}}};
    wire [acc_pkg::RES_W-1:0] res_w    = prec_r ? sample_r : (sample_r & std_mask); // see R2 see R3

    // sequencer next state: one sample period then ten bit periods
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            acc_pkg::ACC_IDLE: begin
                cnt_nxt = '0;
                if (start_ok) begin
                    state_nxt = acc_pkg::ACC_SAMPLE;
                end
            end
            acc_pkg::ACC_SAMPLE: begin
                if (!ctrl.converter_enable) begin
                    state_nxt = acc_pkg::ACC_IDLE;
                end else if (adc_tick) begin // see R11
                    state_nxt = acc_pkg::ACC_CONVERT;
                    cnt_nxt   = '0;
                end
            end
            acc_pkg::ACC_CONVERT: begin
                if (!ctrl.converter_enable || done) begin
                    state_nxt = acc_pkg::ACC_IDLE;
                end else if (adc_tick) begin
                    cnt_nxt = cnt_r + 4'h1; // see R11
                end
            end
        endcase
    end

    // sequencer state and counter
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= acc_pkg::ACC_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // start/status bit: set by accepted start, cleared at completion
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy_r <= 1'b0;
        end else if (start_ok) begin
            busy_r <= 1'b1; // see R14
        end else if (done || !ctrl.converter_enable) begin
            busy_r <= 1'b0; // see R14 see R17
        end
    end

    // mode latched at start, sample caught at end of hold period
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prec_r   <= 1'b0;
            sample_r <= acc_pkg::RESULT_RESET;
        end else begin
            if (start_ok) begin
                prec_r <= ctrl.pseudo_idle_select; // see R4 see R2
            end
            if (in_sample && adc_tick) begin
                sample_r <= sel_code; // see R1
            end
        end
    end

    // result register updated only by a completed conversion
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            result_r <= acc_pkg::RESULT_RESET;
        end else if (done) begin
            result_r <= res_w; // see R3
        end
    end

    // end flag: hardware set wins over software clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            eoc_r <= 1'b0;
        end else if (done) begin
            eoc_r <= 1'b1; // see R15 see R13
        end else if (ctrl.eoc_clear) begin
            eoc_r <= 1'b0; // see R15
        end
    end

    // registered outputs: interrupt, cpu halt, held interrupts, pins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_r  <= 1'b0;
            halt_r <= 1'b0;
            oirq_r <= 1'b0;
            sh_r   <= 1'b0;
            pin_r  <= acc_pkg::CFG_RESET;
        end else begin
            irq_r  <= (eoc_r || done) && eoc_interrupt_enable; // see R13 see R15
            halt_r <= busy_r && prec_r && !done && ctrl.converter_enable; // see R5 see R6
            oirq_r <= other_irq_in && !(busy_r && prec_r && !done); // see R7
            sh_r   <= in_sample;
            pin_r  <= pin_w; // see R8 see R9
        end
    end

    assign status.start_status_bit       = busy_r;
    assign status.end_of_conversion_flag = eoc_r;
    assign status.result                 = result_r;
    assign eoc_irq       = irq_r;
    assign cpu_halt      = halt_r;
    assign other_irq_out = oirq_r;
    assign sample_hold   = sh_r;
    assign pin_is_analog = pin_r;

    // checks
    a_start_ignored: assert property (@(posedge sys_clk) disable iff (!resetn) // see R18
        busy_r && ctrl.start_write |=> $stable(prec_r))
        else $error("start during conversion changed the mode");
    a_unconf_start: assert property (@(posedge sys_clk) disable iff (!resetn) // see R10
        state_r == acc_pkg::ACC_IDLE && ctrl.start_write && !ch_ok |=> !busy_r)
        else $error("start on unconfigured channel was accepted");
    a_eoc_sets: assert property (@(posedge sys_clk) disable iff (!resetn) // see R15
        done |=> eoc_r && !busy_r)
        else $error("completion did not set flag and clear start bit");
    a_irq_follow: assert property (@(posedge sys_clk) disable iff (!resetn) // see R13
        eoc_r && eoc_interrupt_enable |=> irq_r)
        else $error("interrupt not raised with flag and enable");
    a_halt_prec: assert property (@(posedge sys_clk) disable iff (!resetn) // see R5
        halt_r |-> $past(prec_r) && $past(busy_r))
        else $error("cpu halted outside a precision conversion");
    a_hold_other: assert property (@(posedge sys_clk) disable iff (!resetn) // see R7
        busy_r && prec_r && !done |=> !oirq_r)
        else $error("other interrupt passed during precision conversion");
    a_standby_idle: assert property (@(posedge sys_clk) disable iff (!resetn) // see R17
        !ctrl.converter_enable |=> state_r == acc_pkg::ACC_IDLE)
        else $error("conversion running in standby");
    a_conv_length: assert property (@(posedge sys_clk) disable iff (!resetn) // see R11
        in_sample && adc_tick |=> in_conv [*1] ##0 (cnt_r == 4'h0))
        else $error("convert phase did not start at bit zero");
    a_std_mask: assert property (@(posedge sys_clk) disable iff (!resetn) // see R2
        done && !prec_r |=> result_r[1:0] == 2'b00)
        else $error("standard result carries precision bits");
endmodule

// File: common/acc_pkg.sv
// package of constants and carriers for the converter control block
package acc_pkg;

    localparam int NUM_CH       = 8;
    localparam int SEL_W        = 3;
    localparam int RES_W        = 10;
    localparam int STD_BITS     = 8;
    localparam int PRS_W        = 5;
    localparam int CNT_W        = 4;
    // conversion length in adc clock periods
    localparam logic [CNT_W-1:0] SH_PERIODS   = 4'h1;
    localparam logic [CNT_W-1:0] BIT_PERIODS  = 4'hA;
    localparam logic [CNT_W-1:0] CONV_PERIODS = 4'hB;
    // prescaler: prs of zero divides by 64, else by 2*prs
    localparam logic [6:0]       DIV_ZERO_PRS = 7'h40;
    localparam logic [PRS_W-1:0] PRS_RESET    = 5'h00;
    localparam logic [NUM_CH-1:0] CFG_RESET   = 8'h00;
    localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_SAMPLE,
        ACC_CONVERT
    } acc_state_e;

    // software controls of the control register
    typedef struct packed {
        logic             pseudo_idle_select;
        logic             converter_enable;
        logic             start_write;
        logic             eoc_clear;
        logic [SEL_W-1:0] channel_select_field;
    } acc_ctrl_s;

    // status seen by software
    typedef struct packed {
        logic             start_status_bit;
        logic             end_of_conversion_flag;
        logic [RES_W-1:0] result;
    } acc_stat_s;

endpackage

// File: rtl/acc_prescaler.sv
// adc clock tick generator from the peripheral clock
module acc_prescaler (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    // control
    input  wire logic                       run,
    input  wire logic [acc_pkg::PRS_W-1:0]  prs,
    // tick output
    output logic                            adc_tick
);
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    wire  [6:0] div_w = (prs == acc_pkg::PRS_RESET) ? acc_pkg::DIV_ZERO_PRS : {1'b0, prs, 1'b0};
    wire        wrap_w = (cnt_r >= div_w - 7'h01);

    assign cnt_nxt = (!run || wrap_w) ? 7'h00 : cnt_r + 7'h01;

    // divider counter and one-cycle tick
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r    <= 7'h00;
            adc_tick <= 1'b0;
        end else begin
            cnt_r    <= cnt_nxt;
            adc_tick <= run && wrap_w;
        end
    end
endmodule

// File: rtl/acc_chan_mux.sv
// channel routing and pin function selection
module acc_chan_mux (
    // selection
    input  wire logic [acc_pkg::SEL_W-1:0]  channel_select_field,
    input  wire logic [acc_pkg::NUM_CH-1:0] channel_config_reg,
    // per-channel sample codes from the analog front end
    input  wire logic [acc_pkg::RES_W-1:0]  ch_code [acc_pkg::NUM_CH],
    // routed outputs
    output logic [acc_pkg::RES_W-1:0]       selected_analog_input,
    output logic                            channel_allowed,
    output logic [acc_pkg::NUM_CH-1:0]      pin_is_analog
);
    // binary index picks one input, config bits gate it
    assign selected_analog_input = ch_code[channel_select_field]; // see R1 see R16
    assign channel_allowed       = channel_config_reg[channel_select_field]; // see R10
    assign pin_is_analog         = channel_config_reg; // see R8 see R9
endmodule

// File: tb/acc_adc_ctrl_bench.sv
// self-checking bench for the converter control block
module acc_adc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic                sys_clk;
    logic                resetn;
    acc_pkg::acc_ctrl_s  ctrl;
    logic [4:0]          prescale;
    logic [7:0]          cfg;
    logic                irq_en;
    logic [9:0]          codes [8];
    logic                other_in;
    acc_pkg::acc_stat_s  status;
    logic                eoc_irq;
    logic                other_out;
    logic                cpu_halt;
    logic                sample_hold;
    logic [7:0]          pin_an;
    int                  fail_count;
    int                  num_checks;
    int                  cycles;
    int                  n;

    acc_adc_ctrl u_acc_adc_ctrl (
        .sys_clk              (sys_clk),
        .resetn               (resetn),
        .ctrl                 (ctrl),
        .prescale             (prescale),
        .channel_config_reg   (cfg),
        .eoc_interrupt_enable (irq_en),
        .ch_code              (codes),
        .other_irq_in         (other_in),
        .status               (status),
        .eoc_irq              (eoc_irq),
        .other_irq_out        (other_out),
        .cpu_halt             (cpu_halt),
        .sample_hold          (sample_hold),
        .pin_is_analog        (pin_an)
    );

    // 50 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            $display("MISMATCH timeout expected done seen hang");
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one-cycle start pulse, returns one edge after the edge that takes it,
    // so the registered hold and halt outputs have settled
    task automatic start_conv(input logic [2:0] ch, input logic prec);
        @(posedge sys_clk);
        ctrl.channel_select_field <= ch;
        ctrl.pseudo_idle_select   <= prec;
        ctrl.start_write          <= 1'b1;
        @(posedge sys_clk);
        ctrl.start_write <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    // counts cycles until the end flag shows, bounded
    task automatic wait_done(output int cnt);
        cnt = 0;
        while (status.end_of_conversion_flag !== 1'b1 && cnt < 40) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
    endtask

    task automatic clear_flag();
        @(posedge sys_clk);
        ctrl.eoc_clear <= 1'b1;
        @(posedge sys_clk);
        ctrl.eoc_clear <= 1'b0;
        #1;
        chk("flag_clr", 10'h000, 10'(status.end_of_conversion_flag));
    endtask

    task automatic t_reset();
        chk("status_rst", 10'h000, 10'(status.start_status_bit));
        chk("flag_rst", 10'h000, 10'(status.end_of_conversion_flag));
        chk("pins_rst", 10'h000, 10'(pin_an));
    endtask

    // standard mode on every channel, interrupt masked
    task automatic t_channels();
        for (int i = 0; i < 8; i++) begin
            start_conv(3'(i), 1'b0);
            chk("busy", 10'h001, 10'(status.start_status_bit));
            chk("sh", 10'h001, 10'(sample_hold));
            wait_done(n);
            chk("len_ok", 10'h001, 10'(n >= 20 && n <= 24));
            chk("std_res", codes[i] & 10'h3FC, status.result);
            chk("busy_end", 10'h000, 10'(status.start_status_bit));
            repeat (2) @(posedge sys_clk);
            #1;
            chk("irq_mask", 10'h000, 10'(eoc_irq));
            clear_flag();
        end
    endtask

    task automatic t_precision();
        irq_en   <= 1'b1;
        other_in <= 1'b1;
        start_conv(3'h3, 1'b1);
        chk("halt", 10'h001, 10'(cpu_halt));
        repeat (6) @(posedge sys_clk);
        #1;
        chk("held", 10'h000, 10'(other_out));
        wait_done(n);
        chk("halt_end", 10'h000, 10'(cpu_halt));
        chk("prec_res", codes[3], status.result);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("eoc_irq", 10'h001, 10'(eoc_irq));
        chk("released", 10'h001, 10'(other_out));
        clear_flag();
        repeat (2) @(posedge sys_clk);
        #1;
        chk("irq_off", 10'h000, 10'(eoc_irq));
        irq_en   <= 1'b0;
        other_in <= 1'b0;
    endtask

    task automatic t_refused();
        cfg <= 8'hA5;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("pins", 10'h0A5, 10'(pin_an));
        start_conv(3'h1, 1'b0);
        chk("unconf", 10'h000, 10'(status.start_status_bit));
        start_conv(3'h0, 1'b0);
        repeat (4) @(posedge sys_clk);
        start_conv(3'h2, 1'b0);
        wait_done(n);
        chk("keep_res", codes[0] & 10'h3FC, status.result);
        chk("no_restart", 10'h000, 10'(status.start_status_bit));
        clear_flag();
        start_conv(3'h2, 1'b0);
        repeat (4) @(posedge sys_clk);
        ctrl.converter_enable <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("abort", 10'h000, 10'(status.start_status_bit));
        repeat (30) @(posedge sys_clk);
        #1;
        chk("no_flag", 10'h000, 10'(status.end_of_conversion_flag));
        start_conv(3'h2, 1'b0);
        chk("standby", 10'h000, 10'(status.start_status_bit));
    endtask

    // main sequence
    initial begin
        fail_count = 0;
        num_checks = 0;
        cycles     = 0;
        resetn     = 1'b0;
        ctrl       = '0;
        prescale   = 5'h01;
        cfg        = 8'h00;
        irq_en     = 1'b0;
        other_in   = 1'b0;
        for (int i = 0; i < 8; i++) begin
            codes[i] = 10'(i * 10'h07B + 10'h013);
        end
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_reset();
        cfg                   <= 8'hFF;
        ctrl.converter_enable <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_channels();
        t_precision();
        t_refused();
        end_sim();
    end
endmodule
